// ==== rtl/pcipi_align.sv ====
/*
 * Word aligner synchroniser: locks after four K28.5 commas with no decode error between them and
 * drops lock after decode errors. Assumes 10-bit symbols, one per valid.
 */
`timescale 1ns/10ps
module pcipi_align (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic sym_valid,
	input wire logic [9:0] sym,
	input wire logic sym_err,
	output logic locked
);
	typedef enum logic [1:0] {
		PCIPI_A_LOST = 2'b00,
		PCIPI_A_HUNT = 2'b01,
		PCIPI_A_SYNC = 2'b10
	} pcipi_astate_t;

	pcipi_astate_t state;
	pcipi_astate_t next_state;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic comma;

	assign comma = (sym == pcipi_pkg::COMMA_NEG) ||
		(sym == pcipi_pkg::COMMA_POS);

	// Hunt for commas; in sync, four errors in a row drop lock.
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		if (sym_valid)
		begin
			unique case (state)
				PCIPI_A_LOST:
					if (comma)
					begin
						next_state = PCIPI_A_HUNT;
						next_cnt = 3'h1;
					end
				PCIPI_A_HUNT:
					if (sym_err)
						next_state = PCIPI_A_LOST;
					else if (comma)
					begin
						next_cnt = cnt + 3'h1;
						if (next_cnt == pcipi_pkg::LOCK_COMMAS)
						begin
							next_state = PCIPI_A_SYNC;
							next_cnt = 3'h0;
						end
					end
				PCIPI_A_SYNC:
					if (sym_err)
					begin
						next_cnt = cnt + 3'h1;
						if (next_cnt == pcipi_pkg::LOCK_COMMAS)
							next_state = PCIPI_A_LOST;
					end
					else
						next_cnt = 3'h0;
				default:
					next_state = PCIPI_A_LOST;
			endcase
		end
	end

	// State registers.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			state <= PCIPI_A_LOST;
			cnt <= 3'h0;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end

	assign locked = (state == PCIPI_A_SYNC);
endmodule : pcipi_align

// ==== rtl/pcipi_channel.sv ====
/*
 * Per-channel PIPE interface block: electrical idle, receiver detection,
 * loopback, compliance disparity, power states and status, with an
 * Avalon-MM register slave. Assumes one synchronous clock, ref_clk.
 */
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/10ps
module pcipi_channel #(
	parameter int LANE_W = 16
) (
	input wire logic ref_clk,
	input wire logic srst,
	// Register slave port.
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Control levels from the PHY-MAC layer.
	// per-channel power input
	input wire logic [1:0] power_state,
	input wire logic tx_elec_idle_req,
	input wire logic detect_or_loopback_req,
	input wire logic compliance_req,
	// Transmit lane toward the coding section.
	input wire logic [LANE_W-1:0] tx_data,
	input wire logic [1:0] tx_is_k,
	output logic [LANE_W-1:0] pcs_tx_data,
	output logic [1:0] pcs_tx_is_k,
	output logic pcs_force_neg_disp,
	// Transmitter buffer, detection and loopback controls.
	output logic tx_elec_idle,
	output logic rx_detect_start,
	input wire logic rx_detect_result,
	output logic loopback_en,
	// Receive side from the aligner and rate match sections.
	input wire logic rx_sym_valid,
	input wire logic [9:0] rx_sym,
	input wire logic [LANE_W-1:0] pcs_rx_data,
	input wire logic dec_err,
	input wire logic disp_err,
	input wire logic skp_add,
	input wire logic skp_drop,
	input wire logic fifo_over,
	input wire logic fifo_under,
	// Receive lane and status toward the PHY-MAC layer.
	output logic [LANE_W-1:0] rx_data,
	output logic rx_locked,
	output logic phy_op_complete,
	output logic [2:0] rx_status_code
);
	typedef enum logic [1:0] {
		PCIPI_IDLE = 2'b00,
		PCIPI_DETECT = 2'b01,
		PCIPI_PWR = 2'b10
	} pcipi_seq_t;

	pcipi_evt_if evt ();

	// Sequencer and power state.
	pcipi_seq_t seq;
	pcipi_seq_t next_seq;
	pcipi_pkg::pcipi_pstate_t pstate;
	pcipi_pkg::pcipi_pstate_t next_pstate;
	logic [7:0] timer;
	logic [7:0] next_timer;
	logic det_res;
	logic next_det_res;
	// Control register and detection tally.
	logic [31:0] ctrl;
	logic [31:0] next_ctrl;
	logic [15:0] det_count;
	logic [15:0] next_det_count;
	// Read path of the register slave.
	logic [31:0] next_rdata;
	logic rd_pending;
	logic next_rd_pending;
	// Decoded configuration.
	logic gen2_ok;
	logic wide;
	logic low_power;

	// Gen2 is refused unless the hard core path is selected.
	// gen2 gating
	assign gen2_ok = ctrl[pcipi_pkg::CTRL_GEN2] & ctrl[pcipi_pkg::CTRL_HARD];
	assign wide = ctrl[pcipi_pkg::CTRL_WIDE];
	// Every state but P0 counts as low power; idle is all that is applied.
	assign low_power = (pstate != pcipi_pkg::PCIPI_P0);

	// Sequencer: the power state input alone moves pstate, as the MAC
	// owns every transition; detection runs only from P1.
	// A change that arrives during detection waits until the window ends.
	always_comb
	begin
		next_seq = seq;
		next_pstate = pstate;
		next_timer = timer;
		next_det_res = det_res;
		next_det_count = det_count;
		unique case (seq)
			PCIPI_IDLE:
				// A power change wins over a detect request in the same cycle.
				// MAC commanded
				if (power_state != pstate)
				begin
					next_pstate = pcipi_pkg::pcipi_pstate_t'(power_state);
					next_seq = PCIPI_PWR;
				end
				else if (detect_or_loopback_req &&
					pstate == pcipi_pkg::PCIPI_P1)
				begin
					next_seq = PCIPI_DETECT;
					next_timer = pcipi_pkg::DETECT_CNT;
				end
			PCIPI_DETECT:
				// The far-end answer is taken in the last cycle of the window,
				// once the step on the line has had the whole window to settle.
				if (timer == 8'h01)
				begin
					next_seq = PCIPI_IDLE;
					next_det_res = rx_detect_result;
					next_det_count = det_count + 16'h0001;
				end
				else
					next_timer = timer - 8'h01;
			PCIPI_PWR:
				next_seq = PCIPI_IDLE;
			default:
				next_seq = PCIPI_IDLE;
		endcase
	end

	// Completion events toward the encoder, one cycle each.
	// completion source
	assign evt.done = (seq == PCIPI_PWR) ||
		(seq == PCIPI_DETECT && timer == 8'h01);
	// The detect flag only means something alongside done.
	assign evt.detected = (seq == PCIPI_DETECT) && rx_detect_result;
	// Loopback is refused while Gen2 runs on the hard core, as the loop
	// only exists at the Gen1 rate.
	// P0 loopback at Gen1
	assign evt.loopback = detect_or_loopback_req &&
		pstate == pcipi_pkg::PCIPI_P0 && !gen2_ok;

	// Sequencer registers.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			seq <= PCIPI_IDLE;
			// P1 keeps the transmitter idle and lets detection run at once.
			pstate <= pcipi_pkg::PCIPI_P1;
			timer <= 8'h00;
			det_res <= 1'b0;
			det_count <= 16'h0000;
		end
		else
		begin
			seq <= next_seq;
			pstate <= next_pstate;
			timer <= next_timer;
			det_res <= next_det_res;
			det_count <= next_det_count;
		end
	end

	// Transmit path registered toward the PCS. Idle wins in low power.
	// One clock serves both lane and control, so no crossing is needed.
	// lane clocking
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			tx_elec_idle <= 1'b1;
			rx_detect_start <= 1'b0;
			loopback_en <= 1'b0;
			pcs_force_neg_disp <= 1'b0;
			pcs_tx_data <= '0;
			pcs_tx_is_k <= 2'h0;
			rx_data <= '0;
		end
		else
		begin
			tx_elec_idle <= tx_elec_idle_req | low_power;
			rx_detect_start <= (next_seq == PCIPI_DETECT);
			loopback_en <= evt.loopback;
			pcs_force_neg_disp <= compliance_req;
			// In 8-bit mode the upper byte is zero, so stale data never leaks.
			// data transfer
			pcs_tx_data <= wide ? tx_data :
				{{(LANE_W-8){1'b0}}, tx_data[7:0]};
			pcs_tx_is_k <= wide ? tx_is_k : {1'b0, tx_is_k[0]};
			rx_data <= wide ? pcs_rx_data :
				{{(LANE_W-8){1'b0}}, pcs_rx_data[7:0]};
		end
	end

	// Aligner and encoder are separate modules; events reach the encoder
	// through the interface so the sequencer stays free of status logic.
	// comma lock
	pcipi_align u_align (
		.ref_clk(ref_clk),
		.srst(srst),
		.sym_valid(rx_sym_valid),
		.sym(rx_sym),
		.sym_err(dec_err),
		.locked(rx_locked)
	);

	pcipi_status u_status (
		.ref_clk(ref_clk),
		.srst(srst),
		.evt(evt),
		.dec_err(dec_err),
		.disp_err(disp_err),
		.skp_add(skp_add),
		.skp_drop(skp_drop),
		.fifo_over(fifo_over),
		.fifo_under(fifo_under),
		.phy_op_complete(phy_op_complete),
		.rx_status_code(rx_status_code)
	);

	// Register slave: reads wait one cycle so data come from a flop;
	// writes complete in the request cycle.
	always_comb
	begin
		next_ctrl = ctrl;
		next_rdata = avs_readdata;
		next_rd_pending = 1'b0;
		// Only the three defined control bits are kept; the rest read zero.
		if (avs_write && avs_address == pcipi_pkg::REG_CTRL)
			next_ctrl = {29'h0, avs_writedata[2:0]};
		if (avs_read && !rd_pending)
		begin
			next_rd_pending = 1'b1;
			unique case (avs_address)
				pcipi_pkg::REG_CTRL:
					next_rdata = ctrl;
				pcipi_pkg::REG_STAT:
					next_rdata = {24'h0, det_res, rx_locked, loopback_en,
						tx_elec_idle, seq, 2'(pstate)};
				pcipi_pkg::REG_CNT:
					next_rdata = {16'h0, det_count};
				default:
					next_rdata = 32'h0000_0000;
			endcase
		end
	end

	// Writes never wait; a read waits one cycle, and a read held past its
	// answer starts a fresh request, so back-to-back reads work.
	assign avs_waitrequest = avs_read && !rd_pending;

	// Register slave flops.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			// The hard core path is selected out of reset, so the link can
			// train before software has written anything.
			// hard path default
			ctrl <= pcipi_pkg::CTRL_RESET;
			avs_readdata <= 32'h0000_0000;
			rd_pending <= 1'b0;
		end
		else
		begin
			ctrl <= next_ctrl;
			avs_readdata <= next_rdata;
			rd_pending <= next_rd_pending;
		end
	end
endmodule : pcipi_channel

// ==== rtl/pcipi_evt_if.sv ====
/*
 * Interface carrying completion events from the sequencer to the status
 * encoder. Assumes both modports sit in the ref_clk domain.
 */
`timescale 1ns/10ps
interface pcipi_evt_if;
	logic done;
	logic detected;
	logic loopback;
	modport src (output done, output detected, output loopback);
	modport dst (input done, input detected, input loopback);
endinterface : pcipi_evt_if

// ==== rtl/pcipi_pkg.sv ====
/*
 * Shared constants and types for the per-channel PIPE interface block.
 * Assumes a single 20 MHz clock domain and a synchronous reset.
 */
package pcipi_pkg;

	// Power state encodings as carried on the power state input.
	typedef enum logic [1:0] {
		PCIPI_P0 = 2'b00,
		PCIPI_P0S = 2'b01,
		PCIPI_P1 = 2'b10,
		PCIPI_P2 = 2'b11
	} pcipi_pstate_t;

	// Receiver status codes on the 3-bit status output.
	localparam logic [2:0] ST_OK = 3'h0;
	localparam logic [2:0] ST_SKP_ADD = 3'h1;
	localparam logic [2:0] ST_SKP_DROP = 3'h2;
	localparam logic [2:0] ST_RX_PRESENT = 3'h3;
	localparam logic [2:0] ST_DEC_ERR = 3'h4;
	localparam logic [2:0] ST_OVERFLOW = 3'h5;
	localparam logic [2:0] ST_UNDERFLOW = 3'h6;
	localparam logic [2:0] ST_DISP_ERR = 3'h7;

	// Receiver detection timing.
	localparam int CLK_HZ = 20000000;
	localparam int DETECT_NS = 1000;
	localparam int DETECT_CYC = (DETECT_NS * (CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [7:0] DETECT_CNT = 8'(DETECT_CYC);

	// Register map offsets (byte addresses).
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CNT = 4'h8;

	// Control register fields.
	localparam int CTRL_WIDE = 0;
	localparam int CTRL_HARD = 1;
	localparam int CTRL_GEN2 = 2;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

	// K28.5 comma with both disparities, 10-bit.
	localparam logic [9:0] COMMA_NEG = 10'h17C;
	localparam logic [9:0] COMMA_POS = 10'h283;
	localparam logic [2:0] LOCK_COMMAS = 3'h4;

endpackage : pcipi_pkg

// ==== rtl/pcipi_status.sv ====
/*
 * Receiver status encoder: turns completion and receive-side conditions
 * into the 3-bit status code and the one-cycle completion flag.
 * Assumes conditions are single-cycle qualified pulses or levels.
 */
`timescale 1ns/10ps
module pcipi_status (
	input wire logic ref_clk,
	input wire logic srst,
	pcipi_evt_if.dst evt,
	input wire logic dec_err,
	input wire logic disp_err,
	input wire logic skp_add,
	input wire logic skp_drop,
	input wire logic fifo_over,
	input wire logic fifo_under,
	output logic phy_op_complete,
	output logic [2:0] rx_status_code
);
	logic next_done;
	logic [2:0] next_code;

	// Priority follows the usual order: detect result, then errors.
	always_comb
	begin
		next_done = evt.done;
		next_code = pcipi_pkg::ST_OK;
		if (evt.done && evt.detected)
			next_code = pcipi_pkg::ST_RX_PRESENT;
		else if (dec_err)
			next_code = pcipi_pkg::ST_DEC_ERR;
		else if (fifo_over)
			next_code = pcipi_pkg::ST_OVERFLOW;
		else if (fifo_under)
			next_code = pcipi_pkg::ST_UNDERFLOW;
		else if (disp_err)
			next_code = pcipi_pkg::ST_DISP_ERR;
		else if (skp_add)
			next_code = pcipi_pkg::ST_SKP_ADD;
		else if (skp_drop)
			next_code = pcipi_pkg::ST_SKP_DROP;
	end

	// Registered outputs keep the status free of glitches.
	always_ff @(posedge ref_clk)
	begin
		if (srst)
		begin
			phy_op_complete <= 1'b0;
			rx_status_code <= 3'h0;
		end
		else
		begin
			phy_op_complete <= next_done;
			rx_status_code <= next_code;
		end
	end
endmodule : pcipi_status

// ==== tb/pcipi_chk_asserts.sv ====
/*
 * Port checker for the per-channel PIPE interface block.
 * Assumes it is bound to pcipi_channel with one clock, ref_clk.
 */
`timescale 1ns/10ps
module pcipi_chk (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [1:0] power_state,
	input wire logic tx_elec_idle_req,
	input wire logic detect_or_loopback_req,
	input wire logic compliance_req,
	input wire logic dec_err,
	input wire logic pcs_force_neg_disp,
	input wire logic tx_elec_idle,
	input wire logic rx_detect_start,
	input wire logic loopback_en,
	input wire logic phy_op_complete,
	input wire logic [2:0] rx_status_code
);
	// All checks share one domain, so reset disables them all at once.
	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (srst);

	AST_IDLE_REQ: assert property (tx_elec_idle_req |=> tx_elec_idle)
		else $error("idle request not honoured");
	AST_LOW_IDLE: assert property (
		$stable(power_state) && power_state == $past(power_state, 2) &&
		power_state != 2'h0 |=> tx_elec_idle)
		else $error("transmitter not idle in a low-power state");
	AST_DET_LEN: assert property ($rose(rx_detect_start) |->
		rx_detect_start[*8])
		else $error("detection pulse too short");
	AST_DET_DONE: assert property (
		$fell(rx_detect_start) |-> ##[0:1] phy_op_complete)
		else $error("detection ended without completion");
	AST_PULSE: assert property (phy_op_complete |=> !phy_op_complete)
		else $error("completion longer than one cycle");
	AST_DISP: assert property (
		1'b1 |=> pcs_force_neg_disp == $past(compliance_req))
		else $error("disparity override does not follow request");
	AST_PWR_DONE: assert property (
		$changed(power_state) |-> ##[1:4] phy_op_complete)
		else $error("power change not completed");
	AST_STAT_ERR: assert property (
		dec_err && !rx_detect_start |=>
		rx_status_code == pcipi_pkg::ST_DEC_ERR)
		else $error("decode error not reported");
	AST_LOOP: assert property (
		$rose(loopback_en) |-> $past(detect_or_loopback_req))
		else $error("loopback without request");
endmodule : pcipi_chk

bind pcipi_channel pcipi_chk u_pcipi_chk (.ref_clk, .srst, .power_state,
	.tx_elec_idle_req, .detect_or_loopback_req, .compliance_req, .dec_err,
	.pcs_force_neg_disp, .tx_elec_idle, .rx_detect_start, .loopback_en,
	.phy_op_complete, .rx_status_code);

// ==== tb/pcipi_far_rx.sv ====
/*
 * Far-end receiver model answering the detection step on the line.
 * Assumes rx_detect_start stays high for the whole detection window.
 */
`timescale 1ns/10ps
module pcipi_far_rx (
	input wire logic ref_clk,
	input wire logic present,
	input wire logic rx_detect_start,
	output logic rx_detect_result
);
	// Outside a detection the line toggles, so a stale answer never passes.
	always @(posedge ref_clk)
		rx_detect_result <= rx_detect_start ? present : !rx_detect_result;
endmodule : pcipi_far_rx

// ==== tb/tb.sv ====
/*
 * Self-checking bench for the per-channel PIPE interface block.
 * Assumes the far receiver model and the bound port checker.
 */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	logic ref_clk, avs_waitrequest, pcs_force_neg_disp, tx_elec_idle;
	logic rx_detect_start, rx_detect_result, loopback_en, rx_locked;
	logic phy_op_complete, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
	logic tx_elec_idle_req = 1'b0, detect_or_loopback_req = 1'b0;
	logic compliance_req = 1'b0, rx_sym_valid = 1'b0, present = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic [1:0] power_state = 2'h2, tx_is_k = 2'h0, pcs_tx_is_k;
	logic [15:0] tx_data = 16'h0, pcs_rx_data = 16'h0, pcs_tx_data, rx_data;
	logic [9:0] rx_sym = 10'h0;
	logic [5:0] ev = 6'h0;
	logic [2:0] rx_status_code;
	int miscompares = 0;
	int cmp_count = 0;

	pcipi_channel #(.LANE_W(16)) u_pcipi_channel (.ref_clk, .srst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
		.avs_waitrequest, .power_state, .tx_elec_idle_req,
		.detect_or_loopback_req, .compliance_req, .tx_data, .tx_is_k,
		.pcs_tx_data, .pcs_tx_is_k, .pcs_force_neg_disp, .tx_elec_idle,
		.rx_detect_start, .rx_detect_result, .loopback_en, .rx_sym_valid,
		.rx_sym, .pcs_rx_data, .dec_err(ev[0]), .fifo_over(ev[1]),
		.fifo_under(ev[2]), .disp_err(ev[3]), .skp_add(ev[4]),
		.skp_drop(ev[5]), .rx_data, .rx_locked, .phy_op_complete,
		.rx_status_code);
	pcipi_far_rx u_pcipi_far_rx (.ref_clk, .present, .rx_detect_start,
		.rx_detect_result);

	// Free-running 20 MHz clock.
	initial
	begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task automatic conclude;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	// Bus cycle held until waitrequest is seen low; read data lands in q.
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		for (n = 0; n < 20; n++)
		begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0)
				break;
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (n == 20)
		begin
			miscompares++;
			conclude();
		end
	endtask : bus

	// Bounded wait for the completion pulse.
	task automatic wait_done;
		int n;
		for (n = 0; n < 200; n++)
		begin
			@(posedge ref_clk);
			if (phy_op_complete === 1'b1)
				return;
		end
		miscompares++;
		conclude();
	endtask : wait_done

	task automatic t_regs;
		bus(1'b0, pcipi_pkg::REG_CTRL, 32'h0);
		`CHK(q, pcipi_pkg::CTRL_RESET)
		bus(1'b0, pcipi_pkg::REG_STAT, 32'h0);
		`CHK(q, 32'h0000_0012)
		bus(1'b1, pcipi_pkg::REG_CTRL, 32'h0000_0001);
		bus(1'b0, pcipi_pkg::REG_CTRL, 32'h0);
		`CHK(q, 32'h0000_0001)
		bus(1'b0, 4'hC, 32'h0);
		`CHK(q, 32'h0000_0000)
		$display("regs test done");
	endtask : t_regs

	task automatic t_detect;
		@(posedge ref_clk);
		present <= 1'b1;
		detect_or_loopback_req <= 1'b1;
		@(posedge ref_clk);
		detect_or_loopback_req <= 1'b0;
		wait_done();
		`CHK(rx_status_code, pcipi_pkg::ST_RX_PRESENT)
		`CHK(tx_elec_idle, 1'b1)
		bus(1'b0, pcipi_pkg::REG_CNT, 32'h0);
		`CHK(q[15:0], 16'h0001)
		$display("detect test done");
	endtask : t_detect

	task automatic t_power;
		logic [1:0] s [3] = '{2'h1, 2'h3, 2'h0};
		int i;
		for (i = 0; i < 3; i++)
		begin
			@(posedge ref_clk);
			power_state <= s[i];
			wait_done();
			repeat (2) @(posedge ref_clk);
			`CHK(tx_elec_idle, s[i] != 2'h0)
		end
		tx_elec_idle_req <= 1'b1;
		repeat (2) @(posedge ref_clk);
		`CHK(tx_elec_idle, 1'b1)
		tx_elec_idle_req <= 1'b0;
		detect_or_loopback_req <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK(loopback_en, 1'b1)
		`CHK(rx_detect_start, 1'b0)
		detect_or_loopback_req <= 1'b0;
		repeat (3) @(posedge ref_clk);
		`CHK(loopback_en, 1'b0)
		bus(1'b1, pcipi_pkg::REG_CTRL, 32'h0000_0007);
		detect_or_loopback_req <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK(loopback_en, 1'b0)
		detect_or_loopback_req <= 1'b0;
		bus(1'b1, pcipi_pkg::REG_CTRL, 32'h0000_0001);
		$display("power test done");
	endtask : t_power

	task automatic t_lane;
		compliance_req <= 1'b1;
		tx_data <= 16'hA5C3;
		tx_is_k <= 2'h2;
		pcs_rx_data <= 16'h3C5A;
		repeat (2) @(posedge ref_clk);
		`CHK(pcs_force_neg_disp, 1'b1)
		`CHK(pcs_tx_data, 16'hA5C3)
		`CHK(pcs_tx_is_k, 2'h2)
		`CHK(rx_data, 16'h3C5A)
		compliance_req <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK(pcs_force_neg_disp, 1'b0)
		bus(1'b1, pcipi_pkg::REG_CTRL, 32'h0000_0000);
		repeat (2) @(posedge ref_clk);
		`CHK(pcs_tx_data, 16'h00C3)
		`CHK(pcs_tx_is_k, 2'h0)
		`CHK(rx_data, 16'h005A)
		$display("lane test done");
	endtask : t_lane

	// Each receive condition alone must give its own code.
	task automatic t_status;
		logic [2:0] e [6] = '{pcipi_pkg::ST_DEC_ERR, pcipi_pkg::ST_OVERFLOW,
			pcipi_pkg::ST_UNDERFLOW, pcipi_pkg::ST_DISP_ERR,
			pcipi_pkg::ST_SKP_ADD, pcipi_pkg::ST_SKP_DROP};
		int i;
		for (i = 0; i < 6; i++)
		begin
			ev <= 6'h1 << i;
			@(posedge ref_clk);
			ev <= 6'h0;
			@(posedge ref_clk);
			`CHK(rx_status_code, e[i])
		end
		$display("status test done");
	endtask : t_status

	task automatic t_align;
		int i;
		`CHK(rx_locked, 1'b0)
		for (i = 0; i < 4; i++)
		begin
			rx_sym_valid <= 1'b1;
			rx_sym <= i[0] ? pcipi_pkg::COMMA_POS : pcipi_pkg::COMMA_NEG;
			@(posedge ref_clk);
		end
		rx_sym_valid <= 1'b0;
		repeat (2) @(posedge ref_clk);
		`CHK(rx_locked, 1'b1)
		$display("align test done");
	endtask : t_align

	// Two reset cycles, then the scenarios in turn.
	initial
	begin
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		t_regs();
		t_detect();
		t_power();
		t_lane();
		t_status();
		t_align();
		conclude();
	end
endmodule : tb
